// file: logic/fcm_top.sv
// Control logic of a clock-management tile and its clock distribution, as clock enables.
// Assumes pclk stands in for the oscillator, one pclk per 45-degree phase step;
// ref_pin and cc_pin come from outside the pclk domain.
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module fcm_top #(
	parameter int NUM_OUT = 7,
	parameter int NUM_REGIONS = 4
) (
	input wire logic pclk, // Bus and oscillator clock.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB direction.
	input wire logic [7:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error on unmapped address.
	input wire logic ref_pin, // Reference clock pin.
	input wire logic [NUM_REGIONS*4-1:0] cc_pin, // Clock-capable input pins.
	output logic pfd_ref, // Divided reference pulse.
	output logic pfd_fb, // Divided feedback pulse.
	output logic [1:0] bw_mode, // Jitter filter setting.
	output logic [NUM_OUT-1:0] div_clk_en, // Output divider pulses.
	output logic [fcm_pkg::NUM_GLB-1:0] glb_clk, // Global line pulses.
	output logic [NUM_REGIONS*12-1:0] hclk, // Horizontal buffer pulses.
	output logic [NUM_REGIONS*4-1:0] rclk // Regional track pulses.
);
	localparam int NR = NUM_REGIONS;
	localparam int NP = NUM_REGIONS * 4;

	// Refused at elaboration: the register map addresses only these tile shapes.
	if (NUM_OUT < 6 || NUM_OUT > 7 || NR < 1 || NR > 4) begin : g_bad_shape
		$error("unsupported output or region count");
	end

	function automatic logic [7:0] reg_addr(input logic [7:0] base, input int idx);
		reg_addr = base + 8'(idx * 4);
	endfunction

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a[1:0] == 2'h0) && ((a <= fcm_pkg::A_GCE &&
			!(NUM_OUT == 6 && a == reg_addr(fcm_pkg::A_OUT0, 6))) ||
			(a >= fcm_pkg::A_HEN0 && a < reg_addr(fcm_pkg::A_HEN0, NR)) ||
			(a >= fcm_pkg::A_RBUF0 && a < reg_addr(fcm_pkg::A_RBUF0, NR)) ||
			a == fcm_pkg::A_STATUS);
	endfunction

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	logic [31:0] ctrl, gsel, gce, rd_val;
	logic [6:0] div_cfg [NUM_OUT];
	logic [2:0] ph_cfg [NUM_OUT];
	logic [11:0] hen [NR];
	logic [19:0] rcfg [NR];
	logic [2:0] ps_off, facc;
	logic [7:0] ref_ev, fb_ev;
	logic wr;

	// One wait state: pready rises in the first access cycle's next edge.
	assign wr = psel && penable && pready && pwrite && addr_ok(paddr);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && penable && !pready;
			if (psel && penable && !pready) begin
				pslverr <= !addr_ok(paddr);
				prdata <= pwrite ? 32'h0000_0000 : rd_val;
			end
		end
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		if (paddr == fcm_pkg::A_CTRL) rd_val = ctrl;
		if (paddr == fcm_pkg::A_PSHIFT) rd_val = {29'h0, ps_off};
		if (paddr == fcm_pkg::A_GSEL) rd_val = gsel;
		if (paddr == fcm_pkg::A_GCE) rd_val = gce;
		if (paddr == fcm_pkg::A_STATUS) rd_val = {8'h00, fb_ev, ref_ev, 1'b0, facc, 1'b0, ps_off};
		for (int i = 0; i < NUM_OUT; i++) begin
			if (paddr == reg_addr(fcm_pkg::A_OUT0, i)) rd_val = {21'h0, ph_cfg[i], 1'b0, div_cfg[i]};
		end
		for (int r = 0; r < NR; r++) begin
			if (paddr == reg_addr(fcm_pkg::A_HEN0, r)) rd_val = {20'h0, hen[r]};
			if (paddr == reg_addr(fcm_pkg::A_RBUF0, r)) rd_val = {12'h0, rcfg[r]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= fcm_pkg::CTRL_RST;
			gsel <= 32'h0000_0000;
			gce <= fcm_pkg::GCE_RST;
			for (int i = 0; i < NUM_OUT; i++) begin
				div_cfg[i] <= 7'h00;
				ph_cfg[i] <= 3'h0;
			end
			for (int r = 0; r < NR; r++) begin
				hen[r] <= 12'h000;
				rcfg[r] <= 20'h00000;
			end
		end else if (wr) begin
			if (paddr == fcm_pkg::A_CTRL) ctrl <= pwdata;
			if (paddr == fcm_pkg::A_GSEL) gsel <= pwdata;
			if (paddr == fcm_pkg::A_GCE) gce <= pwdata;
			for (int i = 0; i < NUM_OUT; i++) begin
				if (paddr == reg_addr(fcm_pkg::A_OUT0, i)) begin
					div_cfg[i] <= pwdata[6:0];
					ph_cfg[i] <= pwdata[fcm_pkg::OUT_PH_LSB +: 3];
				end
			end
			for (int r = 0; r < NR; r++) begin
				if (paddr == reg_addr(fcm_pkg::A_HEN0, r)) hen[r] <= pwdata[11:0];
				if (paddr == reg_addr(fcm_pkg::A_RBUF0, r)) rcfg[r] <= pwdata[19:0];
			end
		end
	end

	// Fixed offset on a plain write, or one step up or down per command.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) ps_off <= 3'h0;
		else if (wr && paddr == fcm_pkg::A_PSHIFT) begin
			if (pwdata[fcm_pkg::PS_UP_BIT]) ps_off <= ps_off + 3'h1;
			else if (pwdata[fcm_pkg::PS_DN_BIT]) ps_off <= ps_off - 3'h1;
			else ps_off <= pwdata[2:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) bw_mode <= fcm_pkg::CTRL_RST[fcm_pkg::CTRL_BW_LSB +: 2];
		else bw_mode <= ctrl[fcm_pkg::CTRL_BW_LSB +: 2];
	end

	// ------------------------------------------------------------
	// Pre-divider, feedback divider and fractional accumulator
	// ------------------------------------------------------------
	logic ref_s1, ref_s2, ref_s3, ref_rise;
	logic [6:0] d_cnt, d_act, fb_cnt, fb_act;
	logic fb_stretch, term_fb, frac_evt, frac_carry, frac_out;
	logic [2:0] frac, fsel;
	logic [3:0] frac_sum;
	logic [NUM_OUT-1:0] term_o;

	assign ref_rise = ref_s2 && !ref_s3;
	assign frac = ctrl[fcm_pkg::CTRL_FRAC_LSB +: 3];
	assign fsel = ctrl[fcm_pkg::CTRL_FSEL_LSB +: 3];
	assign frac_out = ctrl[fcm_pkg::CTRL_FOUT_BIT];
	assign frac_sum = {1'b0, facc} + {1'b0, frac};
	assign frac_carry = ctrl[fcm_pkg::CTRL_FEN_BIT] && (NUM_OUT == 7) && frac_sum[3];
	assign term_fb = !fb_stretch && fb_cnt == fb_act;
	assign frac_evt = frac_out ? (32'(fsel) < NUM_OUT && term_o[fsel]) : term_fb;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_s1 <= 1'b0;
			ref_s2 <= 1'b0;
			ref_s3 <= 1'b0;
		end else begin
			ref_s1 <= ref_pin;
			ref_s2 <= ref_s1;
			ref_s3 <= ref_s2;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			d_cnt <= 7'h00;
			d_act <= 7'h00;
			pfd_ref <= 1'b0;
			ref_ev <= 8'h00;
		end else begin
			pfd_ref <= 1'b0;
			if (ref_rise) begin
				if (d_cnt == d_act) begin
					d_cnt <= 7'h00;
					d_act <= ctrl[fcm_pkg::CTRL_D_LSB +: 7];
					pfd_ref <= 1'b1;
					ref_ev <= ref_ev + 8'h01;
				end else d_cnt <= d_cnt + 7'h01;
			end
		end
	end

	// With the output route off, a fractional carry holds the feedback count one extra oscillator cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fb_cnt <= 7'h00;
			fb_act <= 7'h00;
			fb_stretch <= 1'b0;
			pfd_fb <= 1'b0;
			fb_ev <= 8'h00;
		end else begin
			pfd_fb <= 1'b0;
			if (fb_stretch) fb_stretch <= 1'b0;
			else if (term_fb) begin
				fb_cnt <= 7'h00;
				fb_act <= ctrl[fcm_pkg::CTRL_M_LSB +: 7];
				pfd_fb <= 1'b1;
				fb_ev <= fb_ev + 8'h01;
				fb_stretch <= frac_carry && !frac_out;
			end else fb_cnt <= fb_cnt + 7'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) facc <= 3'h0;
		else if (!ctrl[fcm_pkg::CTRL_FEN_BIT]) facc <= 3'h0;
		else if (frac_evt) facc <= frac_sum[2:0];
	end

	// ------------------------------------------------------------
	// Phases and output dividers
	// ------------------------------------------------------------
	logic [2:0] vco_ph;
	logic [6:0] cnt_o [NUM_OUT];
	logic [6:0] div_act [NUM_OUT];
	logic [2:0] ph_act [NUM_OUT];
	logic [NUM_OUT-1:0] tick_o, stretch_o;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) vco_ph <= 3'h0;
		else vco_ph <= vco_ph + 3'h1;
	end

	always_comb begin
		for (int i = 0; i < NUM_OUT; i++) begin
			tick_o[i] = vco_ph == 3'(ph_act[i] + ps_off);
			term_o[i] = tick_o[i] && !stretch_o[i] && cnt_o[i] == div_act[i];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_clk_en <= '0;
			stretch_o <= '0;
			for (int i = 0; i < NUM_OUT; i++) begin
				cnt_o[i] <= 7'h00;
				div_act[i] <= 7'h00;
				ph_act[i] <= 3'h0;
			end
		end else begin
			div_clk_en <= term_o;
			for (int i = 0; i < NUM_OUT; i++) begin
				if (tick_o[i]) begin
					if (stretch_o[i]) stretch_o[i] <= 1'b0;
					else if (term_o[i]) begin
						cnt_o[i] <= 7'h00;
						div_act[i] <= div_cfg[i];
						ph_act[i] <= ph_cfg[i];
						stretch_o[i] <= frac_carry && frac_out && 32'(fsel) == i;
					end else cnt_o[i] <= cnt_o[i] + 7'h01;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Global, horizontal and regional buffers
	// ------------------------------------------------------------
	logic [fcm_pkg::NUM_GLB-1:0] gsel_act, gcur;
	logic [NP-1:0] cc_s1, cc_s2, cc_s3, cc_rise, rb_in;
	logic [1:0] rsel_act [NP];
	logic [2:0] rdiv_act [NP];
	logic [2:0] rcnt [NP];

	// On an enabled line a source switch waits for the current source's pulse, so no pulse is cut.
	always_comb begin
		for (int g = 0; g < fcm_pkg::NUM_GLB; g++) begin
			gcur[g] = gsel_act[g] ? div_clk_en[(g + 1) % NUM_OUT] : div_clk_en[g % NUM_OUT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gsel_act <= 32'h0000_0000;
			glb_clk <= 32'h0000_0000;
			hclk <= '0;
		end else begin
			for (int g = 0; g < fcm_pkg::NUM_GLB; g++) begin
				if (gcur[g] || !gce[g]) gsel_act[g] <= gsel[g];
			end
			glb_clk <= gce & gcur;
			for (int r = 0; r < NR; r++) begin
				for (int k = 0; k < fcm_pkg::LINES_PER_REGION; k++) begin
					hclk[r * 12 + k] <= hen[r][k] && glb_clk[(r * 12 + k) % 32];
				end
			end
		end
	end

	assign cc_rise = cc_s2 & ~cc_s3;

	always_comb begin
		for (int j = 0; j < NP; j++) begin
			rb_in[j] = cc_rise[(j / 4) * 4 + 32'(rsel_act[j])];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cc_s1 <= '0;
			cc_s2 <= '0;
			cc_s3 <= '0;
			rclk <= '0;
			for (int j = 0; j < NP; j++) begin
				rsel_act[j] <= 2'h0;
				rdiv_act[j] <= 3'h0;
				rcnt[j] <= 3'h0;
			end
		end else begin
			cc_s1 <= cc_pin;
			cc_s2 <= cc_s1;
			cc_s3 <= cc_s2;
			for (int j = 0; j < NP; j++) begin
				rclk[j] <= rb_in[j] && rcnt[j] == rdiv_act[j];
				if (rb_in[j]) begin
					if (rcnt[j] == rdiv_act[j]) begin
						rcnt[j] <= 3'h0;
						rsel_act[j] <= rcfg[j / 4][(j % 4) * 5 +: 2];
						rdiv_act[j] <= rcfg[j / 4][(j % 4) * 5 + 2 +: 3];
					end else rcnt[j] <= rcnt[j] + 3'h1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_fb_by_two;
		pfd_fb && fb_act == 7'h01 && ctrl[fcm_pkg::CTRL_M_LSB +: 7] == 7'h01 &&
			!ctrl[fcm_pkg::CTRL_FEN_BIT];
	endsequence

	a_ref_pulse_gap: assert property (pfd_ref |=> !pfd_ref)
		else $error("reference pulses back to back");
	a_fb_div_two: assert property (s_fb_by_two |-> ##1 !pfd_fb ##1 pfd_fb)
		else $error("feedback divide by two period wrong");
	a_phase_pick: assert property (div_clk_en[0] |->
		$past(vco_ph) == 3'($past(ph_act[0]) + $past(ps_off)))
		else $error("output pulse not on selected phase");
	a_outdiv_count: assert property (div_clk_en[1] |-> $past(cnt_o[1]) == $past(div_act[1]))
		else $error("output pulse before terminal count");
	a_bw_follow: assert property (wr && paddr == fcm_pkg::A_CTRL |=>
		##1 bw_mode == $past(pwdata[17:16], 2))
		else $error("filter setting not applied");
	a_frac_hold: assert property (term_fb && frac_carry && !frac_out |=> fb_stretch ##1 !pfd_fb)
		else $error("fractional carry did not hold feedback");
	a_pshift_step: assert property (wr && paddr == fcm_pkg::A_PSHIFT && pwdata[8] |=>
		ps_off == 3'($past(ps_off) + 3'h1))
		else $error("phase shift step wrong");
	a_hbuf_gate: assert property (!hen[0][0] |=> !hclk[0])
		else $error("disabled horizontal buffer passed a pulse");
	a_glb_enable: assert property (!gce[3] |=> !glb_clk[3])
		else $error("gated global line passed a pulse");
	a_reload_edge: assert property ($changed(div_act[0]) |-> $past(term_o[0]))
		else $error("divide ratio changed mid period");
endmodule
`default_nettype wire

// file: logic/fcm_pkg.sv
// Package of the clock-manager control block: register map, field layout, reset values.
// Assumes a 32-bit APB register bus with byte addresses in paddr[7:0].
package fcm_pkg;
	localparam int NUM_GLB = 32;
	localparam int LINES_PER_REGION = 12;
	localparam int TRACKS = 4;
	localparam int PHASES = 8;
	localparam int DIV_W = 7;
	localparam int RDIV_W = 3;
	localparam int FRAC_W = 3;
	// Register byte offsets; output divider n sits at A_OUT0 + 4*n.
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_OUT0 = 8'h04;
	localparam logic [7:0] A_PSHIFT = 8'h20;
	localparam logic [7:0] A_GSEL = 8'h24;
	localparam logic [7:0] A_GCE = 8'h28;
	localparam logic [7:0] A_HEN0 = 8'h2C;
	localparam logic [7:0] A_RBUF0 = 8'h3C;
	localparam logic [7:0] A_STATUS = 8'h4C;
	// Field positions.
	localparam int CTRL_D_LSB = 0;
	localparam int CTRL_M_LSB = 8;
	localparam int CTRL_BW_LSB = 16;
	localparam int CTRL_FEN_BIT = 20;
	localparam int CTRL_FOUT_BIT = 21;
	localparam int CTRL_FSEL_LSB = 24;
	localparam int CTRL_FRAC_LSB = 28;
	localparam int OUT_PH_LSB = 8;
	localparam int PS_UP_BIT = 8;
	localparam int PS_DN_BIT = 9;
	localparam int RB_FIELD_W = 5;
	// Input-jitter filter settings.
	localparam logic [1:0] BW_LOW = 2'h0;
	localparam logic [1:0] BW_HIGH = 2'h1;
	localparam logic [1:0] BW_OPT = 2'h2;
	// Reset values: all dividers by one, filter optimised, global and horizontal buffers off; regional tracks have no enable.
	localparam logic [31:0] CTRL_RST = 32'h0002_0000;
	localparam logic [31:0] GCE_RST = 32'h0000_0000;
endpackage

// file: tb/fcm_fabric_model.sv
// Fabric-side model: sources for the reference pin and the clock-capable pins.
// Assumes one clock; pins change just after rising edges of pclk.
`timescale 1ns/1ps
`default_nettype none
module fcm_fabric_model #(
	parameter int REF_HALF = 4,
	parameter int CC_HALF = 3,
	parameter int CC1_HALF = 5
) (
	input wire logic pclk, // Fabric clock.
	input wire logic presetn, // Reset, active low.
	output logic ref_pin, // Reference clock pin.
	output logic [15:0] cc_pin // Clock-capable pins.
);
	int rc;
	int ca;
	int cb;
	logic pa;
	logic pb;
	// ---------------------------------------------------------------
	// Pin sources
	// ---------------------------------------------------------------
	// Half periods of two cycles or more, so the synchroniser sees every level.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc <= 0;
			ca <= 0;
			cb <= 0;
			ref_pin <= 1'b0;
			pa <= 1'b0;
			pb <= 1'b0;
		end else begin
			rc <= (rc == REF_HALF - 1) ? 0 : rc + 1;
			ca <= (ca == CC_HALF - 1) ? 0 : ca + 1;
			cb <= (cb == CC1_HALF - 1) ? 0 : cb + 1;
			if (rc == REF_HALF - 1) ref_pin <= ~ref_pin;
			if (ca == CC_HALF - 1) pa <= ~pa;
			if (cb == CC1_HALF - 1) pb <= ~pb;
		end
	end
	assign cc_pin = {{14{pa}}, pb, pa};
endmodule
`default_nettype wire

// file: tb/fabric_clock_manager_dividers_test.sv
// Self-checking bench of the clock-manager control block: APB registers and pulse outputs.
// Assumes the fabric model drives the reference and clock-capable pins.
`timescale 1ns/1ps
`default_nettype none
module fabric_clock_manager_dividers_test;
	localparam int PFR = 7;
	localparam int PFB = 8;
	localparam int GLB = 9;
	localparam int HCK = 10;
	localparam int RCK = 11;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready, pslverr, ref_pin, pfd_ref, pfd_fb;
	logic [15:0] cc_pin;
	logic [1:0] bw_mode;
	logic [6:0] div_clk_en;
	logic [31:0] glb_clk;
	logic [47:0] hclk;
	logic [15:0] rclk;
	logic [15:0] mon;
	logic [33:0] expq[$];
	logic [33:0] e;
	int fails = 0;
	int checks_done = 0;
	integer seed = 32'h414800AF;
	int i, n, m, d, ph;
	always #2 pclk = ~pclk;
	fcm_top i_fcm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ref_pin(ref_pin), .cc_pin(cc_pin), .pfd_ref(pfd_ref),
		.pfd_fb(pfd_fb), .bw_mode(bw_mode), .div_clk_en(div_clk_en), .glb_clk(glb_clk),
		.hclk(hclk), .rclk(rclk));
	fcm_fabric_model i_fcm_fabric_model (.pclk(pclk), .presetn(presetn), .ref_pin(ref_pin),
		.cc_pin(cc_pin));
	assign mon = {4'h0, rclk[0], hclk[0], glb_clk[0], pfd_fb, pfd_ref, div_clk_en};
	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// For a read, d is the expected data; the monitor compares when pready comes.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
		int k;
		k = 0;
		expq.push_back({~wr, err, d});
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wr ? d : 32'h0;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			fails++;
			report_and_stop();
		end
		@(posedge pclk);
	endtask
	// Cycles from a pulse on line a to the next pulse on line b.
	task automatic gap(input int a, input int b, output int cyc);
		int k;
		k = 0;
		cyc = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (mon[a] !== 1'b1 && k < 3000);
		do begin
			@(posedge pclk);
			cyc++;
		end while (mon[b] !== 1'b1 && cyc < 3000);
		if (k >= 3000 || cyc >= 3000) begin
			fails++;
			report_and_stop();
		end
	endtask
	// Cycles from the pulse that gap last saw to the very next pulse on line b.
	task automatic span(input int b, output int cyc);
		cyc = 0;
		do begin
			@(posedge pclk);
			cyc++;
		end while (mon[b] !== 1'b1 && cyc < 3000);
		if (cyc >= 3000) begin
			fails++;
			report_and_stop();
		end
	endtask
	task automatic count(input int a, input int len, output int c);
		c = 0;
		repeat (len) begin
			@(posedge pclk);
			if (mon[a] === 1'b1) c++;
		end
	endtask
	// ---------------------------------------------------------------
	// Response monitor
	// ---------------------------------------------------------------
	always @(posedge pclk) begin
		if (presetn === 1'b1 && pready === 1'b1) begin
			e = (expq.size() > 0) ? expq.pop_front() : 34'h3_FFFF_FFFF;
			check({31'h0, pslverr}, {31'h0, e[32]});
			if (e[33]) check(prdata, e[31:0]);
		end
	end
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check({30'h0, bw_mode}, {30'h0, fcm_pkg::BW_OPT});
		apb(1'b0, fcm_pkg::A_CTRL, fcm_pkg::CTRL_RST, 1'b0);
		for (i = 0; i < 3; i++) begin
			apb(1'b1, fcm_pkg::A_CTRL, 32'(i) << 16, 1'b0);
			repeat (2) @(posedge pclk);
			check({30'h0, bw_mode}, 32'(i));
		end
		// Small ratios keep the modelled oscillator inside its range.
		apb(1'b1, fcm_pkg::A_CTRL, 32'h0002_0301, 1'b0);
		gap(PFB, PFB, n);
		gap(PFB, PFB, n);
		check(32'(n), 32'h4);
		gap(PFR, PFR, n);
		gap(PFR, PFR, n);
		check(32'(n), 32'h10);
		apb(1'b1, fcm_pkg::A_CTRL, 32'h0002_0101, 1'b0);
		gap(PFB, PFB, n);
		gap(PFB, PFB, n);
		check(32'(n), 32'h2);
		// Half-step fraction in the feedback path: adjacent periods alternate 2 and 3.
		apb(1'b1, fcm_pkg::A_CTRL, 32'h4012_0101, 1'b0);
		gap(PFB, PFB, n);
		span(PFB, m);
		check(32'(n + m), 32'h5);
		apb(1'b1, fcm_pkg::A_OUT0, 32'h0000_0002, 1'b0);
		apb(1'b1, fcm_pkg::A_OUT0 + 8'h04, 32'h0000_0300, 1'b0);
		gap(0, 0, n);
		gap(0, 0, n);
		check(32'(n), 32'h18);
		gap(0, 1, n);
		check(32'(n), 32'h3);
		// Half-step fraction on output 0: adjacent periods alternate three and four ticks.
		apb(1'b1, fcm_pkg::A_CTRL, 32'h4032_0101, 1'b0);
		gap(0, 0, n);
		span(0, m);
		check(32'(n + m), 32'h38);
		apb(1'b1, fcm_pkg::A_CTRL, 32'h0002_0101, 1'b0);
		apb(1'b0, fcm_pkg::A_OUT0, 32'h0000_0002, 1'b0);
		for (i = 2; i < 7; i++) begin
			d = (i == 6) ? 127 : ($random(seed) & 7);
			ph = $random(seed) & 7;
			apb(1'b1, fcm_pkg::A_OUT0 + 8'(4 * i), 32'(d) | (32'(ph) << 8), 1'b0);
			gap(i, i, n);
			gap(i, i, n);
			check(32'(n), 32'(8 * (d + 1)));
		end
		apb(1'b1, fcm_pkg::A_GSEL, 32'h0, 1'b0);
		apb(1'b1, fcm_pkg::A_GCE, 32'h1, 1'b0);
		apb(1'b1, fcm_pkg::A_HEN0, 32'h1, 1'b0);
		apb(1'b0, fcm_pkg::A_HEN0, 32'h1, 1'b0);
		count(GLB, 60, n);
		gap(0, GLB, n);
		check(32'(n), 32'h1);
		gap(GLB, HCK, n);
		check(32'(n), 32'h1);
		apb(1'b1, fcm_pkg::A_HEN0, 32'h0, 1'b0);
		count(HCK, 60, n);
		check(32'(n), 32'h0);
		apb(1'b1, fcm_pkg::A_GSEL, 32'h1, 1'b0);
		count(GLB, 60, n);
		gap(1, GLB, n);
		check(32'(n), 32'h1);
		apb(1'b1, fcm_pkg::A_GCE, 32'h0, 1'b0);
		count(GLB, 60, n);
		check(32'(n), 32'h0);
		apb(1'b1, fcm_pkg::A_RBUF0, 32'h0000_0004, 1'b0);
		gap(RCK, RCK, n);
		gap(RCK, RCK, n);
		check(32'(n), 32'hC);
		apb(1'b1, fcm_pkg::A_RBUF0, 32'h0000_0001, 1'b0);
		apb(1'b0, fcm_pkg::A_RBUF0, 32'h0000_0001, 1'b0);
		gap(RCK, RCK, n);
		gap(RCK, RCK, n);
		check(32'(n), 32'hA);
		apb(1'b1, fcm_pkg::A_PSHIFT, 32'h0000_0100, 1'b0);
		apb(1'b0, fcm_pkg::A_PSHIFT, 32'h0000_0001, 1'b0);
		apb(1'b1, fcm_pkg::A_PSHIFT, 32'h0000_0200, 1'b0);
		apb(1'b1, fcm_pkg::A_PSHIFT, 32'h0000_0200, 1'b0);
		apb(1'b0, fcm_pkg::A_PSHIFT, 32'h0000_0007, 1'b0);
		apb(1'b1, fcm_pkg::A_PSHIFT, 32'h0000_0005, 1'b0);
		apb(1'b0, fcm_pkg::A_PSHIFT, 32'h0000_0005, 1'b0);
		apb(1'b0, 8'h50, 32'h0, 1'b1);
		apb(1'b0, 8'h01, 32'h0, 1'b1);
		apb(1'b1, 8'h50, 32'hFFFF_FFFF, 1'b1);
		repeat (5) @(posedge pclk);
		report_and_stop();
	end
	// A hang anywhere ends the run as a mismatch.
	initial begin
		#200000;
		fails++;
		report_and_stop();
	end
endmodule
`default_nettype wire
